//--- shared/pwm_timer_consts.vh
// constants for the two-channel 8-bit pwm timer block
// assumes inclusion by bare name from the design files
`ifndef PWM_TIMER_CONSTS_VH
`define PWM_TIMER_CONSTS_VH

// ****************************************************
// register indices, byte address is four times these
// ****************************************************
`define IDX_RUN_CTRL      8'h20
`define IDX_CH0_MODE      8'h21
`define IDX_CH1_MODE      8'h22
`define IDX_FF_CTRL       8'h23
`define IDX_IRQ_STATUS    8'h24
`define IDX_IRQ_MASK      8'h25
`define IDX_CH0_COMPARE   8'h26
`define IDX_CH1_COMPARE   8'h27
`define IDX_PIN_CTRL      8'h28
`define IDX_SYS_CLK_CTRL  8'h6e

// ****************************************************
// reset values
// ****************************************************
`define RST_RUN_CTRL      8'h00
`define RST_MODE          8'h00
`define RST_FF_CTRL       8'h00
`define RST_SYS_CLK_CTRL  8'ha0
`define RST_COMPARE       8'h00

// ****************************************************
// field positions
// ****************************************************
`define RUN_PRESCALE_BIT  0
`define RUN_CH0_BIT       1
`define RUN_CH1_BIT       2
`define MODE_OP_BIT       7
`define MODE_DBUF_BIT     6
`define MODE_IRQSEL_BIT   5
`define MODE_PERIOD_HI    4
`define MODE_PERIOD_LO    3
`define MODE_CLK_HI       1
`define MODE_CLK_LO       0
`define SYSCK_WARMUP_BIT  2
`define SYSCK_PRCK_HI     1
`define SYSCK_PRCK_LO     0

// ****************************************************
// codes
// ****************************************************
`define TRG_INV_MATCH     2'h0
`define TRG_INV_OVF       2'h1
`define TRG_OVF_SET       2'h2
`define TRG_MATCH_SET     2'h3
`define FFW_INVERT        2'h0
`define FFW_SET           2'h1
`define FFW_CLEAR         2'h2
`define PRCK_FPH          2'h0
`define PRCK_SLOW         2'h1
`define PRCK_DIV16        2'h2
`define FC16_DIV_CYCLES   4'hf

`endif

//--- src/pwm_channel.v
// one 8-bit pwm / interval timer channel with output flip-flop
// assumes a one-cycle count tick and decoded control from the top
`timescale 1ns/100ps
`include "pwm_timer_consts.vh"

module pwm_channel (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       run,
    input  wire       tick,
    input  wire       op_select,
    input  wire       dbuf_enable,
    input  wire [1:0] period_sel,
    input  wire [1:0] ff_trigger_select,
    input  wire       cmp_wr,
    input  wire [7:0] cmp_wdata,
    input  wire       ff_wr,
    input  wire [1:0] ff_action,
    output reg        output_toggle_ff,
    output reg        match_ev,
    output reg        ovf_ev,
    output reg  [7:0] buf_r
);

    reg  [7:0] up_count;
    reg  [7:0] compare_value_reg;
    wire [7:0] cnt_nxt;
    wire [7:0] top;
    wire       hit;
    wire       ovf;
    wire       match_detect;

    // ****************************************************
    // comparator and overflow detect
    // ****************************************************
    assign top          = (period_sel == 2'h1) ? 8'h3f :
                          (period_sel == 2'h2) ? 8'h7f : 8'hff;
    assign cnt_nxt      = up_count + 8'h01;
    assign match_detect = (cnt_nxt == compare_value_reg);
    assign hit          = run & tick & match_detect;
    assign ovf          = run & tick & ~op_select & (cnt_nxt == top);

    // ****************************************************
    // counter, compare and buffer
    // ****************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_count          <= 8'h00;
            compare_value_reg <= `RST_COMPARE;
            buf_r             <= `RST_COMPARE;
            match_ev          <= 1'b0;
            ovf_ev            <= 1'b0;
        end else begin
            match_ev <= hit;
            ovf_ev   <= ovf;
            if (!run) begin
                up_count <= 8'h00;
            end else if (tick) begin
                if (op_select && match_detect) begin
                    up_count <= 8'h00;
                end else if (ovf) begin
                    up_count <= 8'h00;
                end else begin
                    up_count <= cnt_nxt;
                end
            end
            if (cmp_wr) begin
                buf_r <= cmp_wdata;
                if (!dbuf_enable) begin
                    compare_value_reg <= cmp_wdata;
                end
            end else if (dbuf_enable && (ovf || (op_select && hit))) begin
                compare_value_reg <= buf_r;
            end
        end
    end

    // ****************************************************
    // output flip-flop, register write first, then overflow action
    // ****************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_toggle_ff <= 1'b0;
        end else if (ff_wr && ff_action != 2'h3) begin
            case (ff_action)
                `FFW_SET:   output_toggle_ff <= 1'b1;
                `FFW_CLEAR: output_toggle_ff <= 1'b0;
                default:    output_toggle_ff <= ~output_toggle_ff;
            endcase
        end else begin
            case (ff_trigger_select)
                `TRG_INV_MATCH: begin
                    if (hit) output_toggle_ff <= ~output_toggle_ff;
                end
                `TRG_INV_OVF: begin
                    if (ovf) output_toggle_ff <= ~output_toggle_ff;
                end
                `TRG_OVF_SET: begin
                    if (ovf) output_toggle_ff <= 1'b1;
                    else if (hit) output_toggle_ff <= 1'b0;
                end
                default: begin
                    if (ovf) output_toggle_ff <= 1'b0;
                    else if (hit) output_toggle_ff <= 1'b1;
                end
            endcase
        end
    end

endmodule // pwm_channel

//--- src/pwm_timer_top.v
// two-channel 8-bit pwm timer with apb register access and interrupt
// assumes a single 40 mhz pclk and inputs synchronous to it
//
// Notes on behaviour
// - match detect is asserted whenever counter plus one equals the compare value.
// - in interval timer mode a compare match clears the counter.
// - toggle trigger codes invert the output on match or on overflow.
// - output flip-flop reaches the pin, which is shared with a port bit.
// - pwm code 2 clears output on match and sets it on overflow.
// - pwm code 3 sets output on match and clears it on overflow.
// - in pwm mode the counter clears at the selected 2^n-1 value.
// - when match and overflow coincide the overflow action wins.
// - with double buffering, buffer moves to compare register on overflow, or on match in interval timer mode.
// - each channel also works alone as an 8-bit interval timer.
// - reset clears operating mode to zero, which is pwm mode.
// - reading the compare address returns the buffer, active register hidden.
`timescale 1ns/100ps
`include "pwm_timer_consts.vh"

module pwm_timer_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        slow_clk_tick,
    output reg  [1:0]  pwm_out_pin,
    output reg         irq
);

    // ****************************************************
    // registers
    // ****************************************************
    reg  [7:0] run_control_reg;
    reg  [7:0] channel0_mode_reg;
    reg  [7:0] channel1_mode_reg;
    reg  [7:0] ff_control_reg;
    reg  [7:0] system_clock_control;
    reg  [7:0] pin_ctrl_r;
    reg  [3:0] irq_status_r;
    reg  [3:0] irq_mask_r;
    reg  [3:0] fc16_cnt_r;
    reg  [5:0] pre_cnt_r;

    wire       acc;
    wire       wr;
    wire       src_tick;
    wire       tick_p1;
    wire       tick_p4;
    wire       tick_p16;
    wire [1:0] ff_out;
    wire [1:0] match_ev;
    wire [1:0] ovf_ev;
    wire [7:0] buf0;
    wire [7:0] buf1;
    wire [3:0] ev;
    wire [1:0] prescale_source_sel;
    wire       tick0;
    wire       tick1;
    wire       ff_wr;
    wire       cmp0_wr;
    wire       cmp1_wr;
    wire       st_wr;
    wire       irq_nxt;
    wire [3:0] irq_status_nxt;
    reg  [7:0] rd_byte;
    reg        rd_ok;

    function hit_addr;
        input [11:0] a;
        input [7:0]  idx;
        begin
            hit_addr = (a == {2'h0, idx, 2'h0});
        end
    endfunction

    function clk_tick;
        input [1:0] sel;
        input       p1;
        input       p4;
        input       p16;
        begin
            case (sel)
                2'h1:    clk_tick = p1;
                2'h2:    clk_tick = p4;
                2'h3:    clk_tick = p16;
                default: clk_tick = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************
    // apb access
    // ****************************************************
    assign acc = psel & penable & pready;
    assign wr  = acc & pwrite & ~pslverr;

    always @* begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        if (hit_addr(paddr, `IDX_RUN_CTRL)) begin
            rd_byte = run_control_reg;
        end else if (hit_addr(paddr, `IDX_CH0_MODE)) begin
            rd_byte = channel0_mode_reg;
        end else if (hit_addr(paddr, `IDX_CH1_MODE)) begin
            rd_byte = channel1_mode_reg;
        end else if (hit_addr(paddr, `IDX_FF_CTRL)) begin
            rd_byte = {2'h0, ff_control_reg[5:4], 2'h0, ff_control_reg[1:0]};
        end else if (hit_addr(paddr, `IDX_IRQ_STATUS)) begin
            rd_byte = {4'h0, irq_status_r};
        end else if (hit_addr(paddr, `IDX_IRQ_MASK)) begin
            rd_byte = {4'h0, irq_mask_r};
        end else if (hit_addr(paddr, `IDX_CH0_COMPARE)) begin
            rd_byte = buf0;
        end else if (hit_addr(paddr, `IDX_CH1_COMPARE)) begin
            rd_byte = buf1;
        end else if (hit_addr(paddr, `IDX_PIN_CTRL)) begin
            rd_byte = pin_ctrl_r;
        end else if (hit_addr(paddr, `IDX_SYS_CLK_CTRL)) begin
            rd_byte = system_clock_control & 8'hfb;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~rd_ok;
            if (psel && !penable) begin
                prdata <= {24'h000000, rd_byte};
            end
        end
    end

    // ****************************************************
    // control registers
    // ****************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_control_reg      <= `RST_RUN_CTRL;
            channel0_mode_reg    <= `RST_MODE;
            channel1_mode_reg    <= `RST_MODE;
            ff_control_reg       <= `RST_FF_CTRL;
            system_clock_control <= `RST_SYS_CLK_CTRL;
            pin_ctrl_r           <= 8'h00;
            irq_mask_r           <= 4'h0;
        end else if (wr) begin
            if (hit_addr(paddr, `IDX_RUN_CTRL)) begin
                run_control_reg <= pwdata[7:0];
            end
            if (hit_addr(paddr, `IDX_CH0_MODE)) begin
                channel0_mode_reg <= pwdata[7:0];
            end
            if (hit_addr(paddr, `IDX_CH1_MODE)) begin
                channel1_mode_reg <= pwdata[7:0];
            end
            if (hit_addr(paddr, `IDX_FF_CTRL)) begin
                ff_control_reg <= pwdata[7:0];
            end
            if (hit_addr(paddr, `IDX_SYS_CLK_CTRL)) begin
                system_clock_control <= pwdata[7:0];
            end
            if (hit_addr(paddr, `IDX_PIN_CTRL)) begin
                pin_ctrl_r <= pwdata[7:0];
            end
            if (hit_addr(paddr, `IDX_IRQ_MASK)) begin
                irq_mask_r <= pwdata[3:0];
            end
        end
    end

    // ****************************************************
    // prescaler
    // ****************************************************
    assign prescale_source_sel = system_clock_control[`SYSCK_PRCK_HI:`SYSCK_PRCK_LO];
    assign src_tick = (prescale_source_sel == `PRCK_FPH)   ? 1'b1 :
                      (prescale_source_sel == `PRCK_SLOW)  ? slow_clk_tick :
                      (prescale_source_sel == `PRCK_DIV16) ? (fc16_cnt_r == `FC16_DIV_CYCLES) :
                      1'b0;
    assign tick_p1  = src_tick & (pre_cnt_r[1:0] == 2'h3);
    assign tick_p4  = src_tick & (pre_cnt_r[3:0] == 4'hf);
    assign tick_p16 = src_tick & (pre_cnt_r == 6'h3f);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fc16_cnt_r <= 4'h0;
            pre_cnt_r  <= 6'h00;
        end else begin
            fc16_cnt_r <= fc16_cnt_r + 4'h1;
            if (!run_control_reg[`RUN_PRESCALE_BIT]) begin
                pre_cnt_r <= 6'h00;
            end else if (src_tick) begin
                pre_cnt_r <= pre_cnt_r + 6'h01;
            end
        end
    end

    // ****************************************************
    // per-channel strobes and count ticks
    // ****************************************************
    assign ff_wr   = wr & hit_addr(paddr, `IDX_FF_CTRL);
    assign cmp0_wr = wr & hit_addr(paddr, `IDX_CH0_COMPARE);
    assign cmp1_wr = wr & hit_addr(paddr, `IDX_CH1_COMPARE);
    assign tick0   = clk_tick(channel0_mode_reg[`MODE_CLK_HI:`MODE_CLK_LO],
                              tick_p1, tick_p4, tick_p16);
    assign tick1   = clk_tick(channel1_mode_reg[`MODE_CLK_HI:`MODE_CLK_LO],
                              tick_p1, tick_p4, tick_p16);

    // ****************************************************
    // channels
    // ****************************************************
    pwm_channel u_ch0 (
        .pclk              (pclk),
        .presetn           (presetn),
        .run               (run_control_reg[`RUN_CH0_BIT]),
        .tick              (tick0),
        .op_select         (channel0_mode_reg[`MODE_OP_BIT]),
        .dbuf_enable       (channel0_mode_reg[`MODE_DBUF_BIT]),
        .period_sel        (channel0_mode_reg[`MODE_PERIOD_HI:`MODE_PERIOD_LO]),
        .ff_trigger_select (ff_control_reg[1:0]),
        .cmp_wr            (cmp0_wr),
        .cmp_wdata         (pwdata[7:0]),
        .ff_wr             (ff_wr),
        .ff_action         (pwdata[3:2]),
        .output_toggle_ff  (ff_out[0]),
        .match_ev          (match_ev[0]),
        .ovf_ev            (ovf_ev[0]),
        .buf_r             (buf0)
    );

    pwm_channel u_ch1 (
        .pclk              (pclk),
        .presetn           (presetn),
        .run               (run_control_reg[`RUN_CH1_BIT]),
        .tick              (tick1),
        .op_select         (channel1_mode_reg[`MODE_OP_BIT]),
        .dbuf_enable       (channel1_mode_reg[`MODE_DBUF_BIT]),
        .period_sel        (channel1_mode_reg[`MODE_PERIOD_HI:`MODE_PERIOD_LO]),
        .ff_trigger_select (ff_control_reg[5:4]),
        .cmp_wr            (cmp1_wr),
        .cmp_wdata         (pwdata[7:0]),
        .ff_wr             (ff_wr),
        .ff_action         (pwdata[7:6]),
        .output_toggle_ff  (ff_out[1]),
        .match_ev          (match_ev[1]),
        .ovf_ev            (ovf_ev[1]),
        .buf_r             (buf1)
    );

    // ****************************************************
    // pins and interrupt
    // ****************************************************
    assign ev[0] = channel0_mode_reg[`MODE_IRQSEL_BIT] ? match_ev[0] : ovf_ev[0];
    assign ev[1] = channel1_mode_reg[`MODE_IRQSEL_BIT] ? match_ev[1] : ovf_ev[1];
    assign ev[2] = match_ev[0];
    assign ev[3] = match_ev[1];

    assign st_wr          = wr & hit_addr(paddr, `IDX_IRQ_STATUS);
    assign irq_status_nxt = st_wr ? ((irq_status_r & ~pwdata[3:0]) | ev) :
                                    (irq_status_r | ev);
    assign irq_nxt        = |(irq_status_r & irq_mask_r);

    // event set wins over a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= 4'h0;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

    // ****************************************************
    // output pins
    // ****************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out_pin <= 2'h0;
        end else begin
            pwm_out_pin[0] <= pin_ctrl_r[0] ? ff_out[0] : pin_ctrl_r[4];
            pwm_out_pin[1] <= pin_ctrl_r[1] ? ff_out[1] : pin_ctrl_r[5];
        end
    end

endmodule // pwm_timer_top

//--- dv/pwm_timer_top_properties.sv
// port checker for the two-channel pwm timer
// assumes binding onto pwm_timer_top, one pclk domain
`timescale 1ns/100ps
// ****************************************************
// checker
// ****************************************************
module pwm_timer_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [1:0]  pwm_out_pin,
    input wire        irq
);
    wire wr_done = pready && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_next;
        psel && !penable |=> pready;
    endproperty
    a_ready_next: assert property (p_ready_next)
        else $error("no ready after setup");
    property p_ready_single;
        pready |=> !pready;
    endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready longer than one cycle");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready)
        else $error("error without ready");
    property p_rdata_hi;
        pready |-> prdata[31:8] == 24'h0;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi)
        else $error("upper read data not zero");
    property p_unmapped;
        psel && !penable && !pwrite && paddr == 12'h000 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    property p_mapped;
        psel && !penable && paddr == 12'h098 |=> pready && !pslverr;
    endproperty
    a_mapped: assert property (p_mapped)
        else $error("compare access refused");
    property p_irq_fall;
        $fell(irq) |-> $past(wr_done, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
    property p_reset_quiet;
        $rose(presetn) |-> !irq && pwm_out_pin == 2'b00 && !pready;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active after reset");
endmodule // pwm_timer_props

bind pwm_timer_top pwm_timer_props u_pwm_timer_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_out_pin(pwm_out_pin), .irq(irq));

//--- dv/pwm_load.sv
// external load on a timer pin, measures level widths in clocks
// assumes a pin that is always driven
`timescale 1ns/100ps
// ****************************************************
// load model
// ****************************************************
module pwm_load (
    input wire          clk,
    input wire          pin,
    output logic [15:0] hi_w,
    output logic [15:0] lo_w,
    output logic [15:0] edges
);
    logic [15:0] run_len;
    logic        last;
    initial begin
        hi_w = 16'h0;
        lo_w = 16'h0;
        edges = 16'h0;
        run_len = 16'h0;
        last = 1'b0;
    end
    always @(posedge clk) begin
        if (pin !== last) begin
            if (last) hi_w <= run_len;
            else lo_w <= run_len;
            run_len <= 16'h1;
            edges <= edges + 16'h1;
            last <= pin;
        end else run_len <= run_len + 16'h1;
    end
endmodule // pwm_load

//--- dv/test_eight_bit_pwm_timer_output.sv
// self-checking bench for the pwm timer, channel 0 and one channel 1 case via apb
// assumes the constants header on the include path
`timescale 1ns/100ps
`include "pwm_timer_consts.vh"
module test_eight_bit_pwm_timer_output;
    localparam int TICK = 4;
    localparam int TOP = 63;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic        slow_clk_tick;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [1:0]  pwm_out_pin;
    wire         irq;
    wire  [15:0] hi_w;
    wire  [15:0] lo_w;
    wire  [15:0] edges;
    logic [31:0] rdat;
    logic        rerr;
    int          fail_count;
    int          check_count;
    pwm_timer_top u_pwm_timer_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .slow_clk_tick(slow_clk_tick),
        .pwm_out_pin(pwm_out_pin), .irq(irq));
    pwm_load u_pwm_load (.clk(pclk), .pin(pwm_out_pin[0]), .hi_w(hi_w), .lo_w(lo_w),
        .edges(edges));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ****************************************************
    // common tasks
    // ****************************************************
    task close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("BAD pready expected 1 seen timeout");
            close_out;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pwm_cfg(input logic [7:0] mode, input logic [7:0] cmp, input logic [1:0] trg);
        bus(1'b1, `IDX_RUN_CTRL, 8'h00);
        bus(1'b1, `IDX_CH0_MODE, mode);
        bus(1'b1, `IDX_CH0_COMPARE, cmp);
        bus(1'b1, `IDX_FF_CTRL, {6'h32, trg});
        bus(1'b1, `IDX_PIN_CTRL, 8'h01);
        bus(1'b1, `IDX_RUN_CTRL, 8'h03);
        repeat (760) @(posedge pclk);
    endtask
    // ****************************************************
    // scenarios
    // ****************************************************
    task scen_reset;
        bus(1'b0, `IDX_SYS_CLK_CTRL, 8'h00);
        chk("sysclk reset", 32'ha0, rdat);
        bus(1'b0, `IDX_CH0_MODE, 8'h00);
        chk("mode reset", 32'h0, rdat);
        bus(1'b0, 8'h00, 8'h00);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        bus(1'b1, `IDX_SYS_CLK_CTRL, 8'h5c);
        bus(1'b0, `IDX_SYS_CLK_CTRL, 8'h00);
        chk("sysclk rw", 32'h58, rdat);
        bus(1'b1, `IDX_SYS_CLK_CTRL, 8'ha0);
    endtask
    task scen_port_pin;
        bus(1'b1, `IDX_PIN_CTRL, 8'h30);
        repeat (3) @(posedge pclk);
        chk("port pins high", 32'h3, {30'h0, pwm_out_pin});
        bus(1'b1, `IDX_PIN_CTRL, 8'h00);
        repeat (3) @(posedge pclk);
        chk("port pins low", 32'h0, {30'h0, pwm_out_pin});
    endtask
    task scen_pwm(input logic [1:0] trg, input logic [7:0] cmp, input int ehi, input int elo);
        pwm_cfg(8'h09, cmp, trg);
        chk("high width", ehi, {16'h0, hi_w});
        chk("low width", elo, {16'h0, lo_w});
    endtask
    task scen_const(input logic [1:0] trg, input logic lvl);
        logic [15:0] e;
        pwm_cfg(8'h09, 8'h3f, trg);
        e = edges;
        repeat (300) @(posedge pclk);
        chk("const edges", {16'h0, e}, {16'h0, edges});
        chk("const level", {31'h0, lvl}, {31'h0, pwm_out_pin[0]});
    endtask
    task scen_dbuf;
        pwm_cfg(8'h09, 8'h20, 2'h2);
        bus(1'b1, `IDX_CH0_MODE, 8'h49);
        bus(1'b1, `IDX_CH0_COMPARE, 8'h10);
        bus(1'b0, `IDX_CH0_COMPARE, 8'h00);
        chk("buffer read", 32'h10, rdat);
        repeat (760) @(posedge pclk);
        chk("dbuf width", 16 * TICK, {16'h0, hi_w});
    endtask
    task scen_timer;
        int n;
        pwm_cfg(8'ha1, 8'h05, 2'h0);
        chk("timer high", 5 * TICK, {16'h0, hi_w});
        chk("timer low", 5 * TICK, {16'h0, lo_w});
        bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
        chk("match status", 32'h5, rdat & 32'h5);
        chk("masked irq", 32'h0, {31'h0, irq});
        bus(1'b1, `IDX_IRQ_MASK, 8'h01);
        for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, `IDX_RUN_CTRL, 8'h00);
        bus(1'b1, `IDX_IRQ_STATUS, 8'h0f);
        repeat (3) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask
    task scen_ch1;
        logic p;
        bus(1'b1, `IDX_CH1_MODE, 8'ha1);
        bus(1'b1, `IDX_CH1_COMPARE, 8'h05);
        bus(1'b1, `IDX_PIN_CTRL, 8'h02);
        bus(1'b1, `IDX_RUN_CTRL, 8'h05);
        repeat (100) @(posedge pclk);
        p = pwm_out_pin[1];
        repeat (5 * TICK) @(posedge pclk);
        chk("ch1 toggle", {31'h0, ~p}, {31'h0, pwm_out_pin[1]});
        bus(1'b0, `IDX_IRQ_STATUS, 8'h00);
        chk("ch1 match status", 32'h8, rdat & 32'h8);
    endtask
    // ****************************************************
    // main sequence and watchdog
    // ****************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        slow_clk_tick = 1'b0;
        fail_count = 0;
        check_count = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        scen_reset;
        scen_port_pin;
        scen_pwm(2'h2, 8'h20, 32 * TICK, 31 * TICK);
        scen_pwm(2'h3, 8'h20, 31 * TICK, 32 * TICK);
        scen_pwm(2'h1, 8'h20, TOP * TICK, TOP * TICK);
        scen_pwm(2'h0, 8'h20, TOP * TICK, TOP * TICK);
        scen_const(2'h2, 1'b1);
        scen_const(2'h3, 1'b0);
        scen_dbuf;
        scen_timer;
        scen_ch1;
        close_out;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        $display("BAD run expected finish seen timeout");
        close_out;
    end
endmodule // test_eight_bit_pwm_timer_output
